// ==== verilog/dcbmf_pkg.sv ====
// package: constants and behaviour notes for the bus-matching fifo port block
//------------------------------------------------------------------------------
// Notes on behaviour
// - read width strap: low x18, high x9
// - almost-empty high once count reaches empty offset
// - almost-full high while free exceeds full offset
// - flag timing strap: low async, high sync
// - partial reset clears pointers, output; keeps settings
// - x9 read drives only low nine outputs
// - synchronous standard-mode reads only while read enable asserted
// - synchronous reads on clock edge with enable
// - load select low: reads return offset registers
// - async read: one word per strobe rise
// - retransmit latency strap: low zero, high normal
// - replay zeroes read address, signals empty
// - serial offset load only with serial enable
// - synchronous writes on clock edge with gate
// - async write: one word per strobe rise
// - writes only while write gate asserted
// - write width strap: low x18, high x9
// - fall-through: valid flag; standard: empty flag
// - master reset clears pointers, latches straps
//------------------------------------------------------------------------------
package dcbmf_pkg;
    localparam int WORD_W = 18;
    localparam int HALF_W = 9;
    localparam int DEF_DEPTH = 131072;
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_EMPTY_OFS = 8'h00;
    localparam logic [7:0] REG_FULL_OFS = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_AE_BIT = 2;
    localparam int ST_AF_BIT = 3;
    localparam int ST_CNT_LSB = 8;
    localparam int CF_RD9 = 0;
    localparam int CF_WR9 = 1;
    localparam int CF_FSYNC = 2;
    localparam int CF_RTNORM = 3;
    localparam int CF_FALL_THROUGH_MODE = 4;
    localparam int CF_SERIAL = 5;
    localparam int CF_ASYR = 6;
    localparam int CF_ASYW = 7;
    localparam int DEF_EMPTY_OFS = 127;
    localparam int DEF_FULL_OFS = 127;
endpackage

// ==== verilog/dcbmf_ram.sv ====
// module: storage array, one write port, combinational read port
module dcbmf_ram
#(
    parameter int WIDTH = 18,
    parameter int DEPTH = 131072
)
(
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule

// ==== verilog/dcbmf_ports.sv ====
// module: port control of the dual-width fifo with offset flags and axi4-lite view
module dcbmf_ports
    import dcbmf_pkg::*;
#(
    parameter int DEPTH = DEF_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic masterResetN,
    input wire logic partialResetN,
    input wire logic readWidthSelect,
    input wire logic writeWidthSelect,
    input wire logic flagTimingSelect,
    input wire logic retransmitLatencySelect,
    input wire logic fallThroughMode,
    input wire logic offsetLoadSelect,
    input wire logic asyncReadSelect,
    input wire logic asyncWriteSelect,
    input wire logic serialLoadEnable,
    input wire logic inputStrobeGate,
    input wire logic inputStrobe,
    input wire logic [WORD_W-1:0] dataIn,
    input wire logic readStrobeEnable,
    input wire logic readStrobe,
    input wire logic replayRequest,
    output logic [WORD_W-1:0] dataOut,
    output logic emptyFlag,
    output logic fullFlag,
    output logic almostEmptyFlag,
    output logic almostFullFlag
);
    localparam int ADDR_W = $clog2(DEPTH);
    localparam int CNT_W = ADDR_W + 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    typedef enum logic [1:0] {BUS_IDLE, BUS_ACK, BUS_RESP} dcbmf_bus_t;

    typedef struct packed {
        dcbmf_bus_t wrBus;
        dcbmf_bus_t rdBus;
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic read9, write9, flagSync, retransNormal, fall_through_mode, serialMethod;
        logic asyncRead, asyncWrite;
        logic [CNT_W-1:0] emptyOfs;
        logic [CNT_W-1:0] fullOfs;
        logic [CNT_W-1:0] wrPtr;
        logic [CNT_W-1:0] rdPtr;
        logic packHave;
        logic [HALF_W-1:0] packLow;
        logic halfSel, outValid, readBlock;
        logic [WORD_W-1:0] outWord;
        logic [WORD_W-1:0] dataOut;
        logic wrOfsSel, rdOfsSel, prevWrStrobe, prevRdStrobe;
        logic emptyFlag, fullFlag, almostEmptyFlag, almostFullFlag;
    } dcbmf_state_t;

    dcbmf_state_t s;
    dcbmf_state_t n;
    logic [WORD_W-1:0] memQ;
    logic memWe;
    logic [WORD_W-1:0] memData;
    logic wrEvent;
    logic rdEvent;
    logic [CNT_W-1:0] curCount;
    logic [CNT_W-1:0] nextCount;
    logic [CNT_W-1:0] cntSel;
    logic axiOfs;
    logic forceEmpty;
    logic doLoad;
    logic takeHigh;
    logic notEmpty;

    function automatic logic [CNT_W-1:0] countOf(input logic [CNT_W-1:0] wp,
                                                 input logic [CNT_W-1:0] rp);
        return wp - rp;
    endfunction

    function automatic logic [CNT_W-1:0] applyStrb(input logic [CNT_W-1:0] old,
                                                   input logic [31:0] data,
                                                   input logic [3:0] strb);
        logic [31:0] merged;
        merged = 32'(old);
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                merged[8*i +: 8] = data[8*i +: 8];
            end
        end
        return merged[CNT_W-1:0];
    endfunction

    //--------------------------------------------------------------------------
    // request qualification
    //--------------------------------------------------------------------------
    // async write needs a strobe rise and the gate
    assign wrEvent = inputStrobeGate && (!s.asyncWrite || (inputStrobe && !s.prevWrStrobe));
    // async read: strobe rise; sync read: enable per edge
    assign rdEvent = s.asyncRead ? (readStrobe && !s.prevRdStrobe) : readStrobeEnable;
    assign curCount = countOf(s.wrPtr, s.rdPtr);

    dcbmf_ram #(.WIDTH(WORD_W), .DEPTH(DEPTH)) u_ram (
        .sys_clk(sys_clk),
        .we(memWe),
        .waddr(s.wrPtr[ADDR_W-1:0]),
        .wdata(memData),
        .raddr(s.rdPtr[ADDR_W-1:0]),
        .rdata(memQ)
    );

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb
    begin
        n = s;
        memWe = 1'b0;
        memData = '0;
        axiOfs = 1'b0;
        forceEmpty = 1'b0;
        doLoad = 1'b0;
        takeHigh = s.read9 && s.halfSel;
        notEmpty = curCount != '0;
        n.prevWrStrobe = inputStrobe;
        n.prevRdStrobe = readStrobe;
        n.readBlock = 1'b0;

        // axi write channel: take address and data together, then respond
        case (s.wrBus)
            BUS_IDLE:
            begin
                if (awvalid && wvalid)
                begin
                    n.awready = 1'b1;
                    n.wready = 1'b1;
                    n.wrBus = BUS_ACK;
                end
            end
            BUS_ACK:
            begin
                n.awready = 1'b0;
                n.wready = 1'b0;
                n.bvalid = 1'b1;
                n.bresp = RESP_OKAY;
                n.wrBus = BUS_RESP;
                case (awaddr)
                    REG_EMPTY_OFS:
                    begin
                        n.emptyOfs = applyStrb(s.emptyOfs, wdata, wstrb);
                        axiOfs = 1'b1;
                    end
                    REG_FULL_OFS:
                    begin
                        n.fullOfs = applyStrb(s.fullOfs, wdata, wstrb);
                        axiOfs = 1'b1;
                    end
                    REG_STATUS, REG_CONFIG:
                    begin
                        n.bresp = RESP_OKAY;
                    end
                    default:
                    begin
                        n.bresp = RESP_SLVERR;
                    end
                endcase
            end
            BUS_RESP:
            begin
                if (bready)
                begin
                    n.bvalid = 1'b0;
                    n.wrBus = BUS_IDLE;
                end
            end
            default:
            begin
                n.wrBus = BUS_IDLE;
            end
        endcase

        // axi read channel
        case (s.rdBus)
            BUS_IDLE:
            begin
                if (arvalid)
                begin
                    n.arready = 1'b1;
                    n.rdBus = BUS_ACK;
                end
            end
            BUS_ACK:
            begin
                n.arready = 1'b0;
                n.rvalid = 1'b1;
                n.rresp = RESP_OKAY;
                n.rdata = '0;
                n.rdBus = BUS_RESP;
                case (araddr)
                    REG_EMPTY_OFS:
                    begin
                        n.rdata = 32'(s.emptyOfs);
                    end
                    REG_FULL_OFS:
                    begin
                        n.rdata = 32'(s.fullOfs);
                    end
                    REG_STATUS:
                    begin
                        n.rdata[ST_EMPTY_BIT] = s.emptyFlag;
                        n.rdata[ST_FULL_BIT] = s.fullFlag;
                        n.rdata[ST_AE_BIT] = s.almostEmptyFlag;
                        n.rdata[ST_AF_BIT] = s.almostFullFlag;
                        n.rdata[ST_CNT_LSB +: CNT_W] = curCount;
                    end
                    REG_CONFIG:
                    begin
                        n.rdata[CF_RD9] = s.read9;
                        n.rdata[CF_WR9] = s.write9;
                        n.rdata[CF_FSYNC] = s.flagSync;
                        n.rdata[CF_RTNORM] = s.retransNormal;
                        n.rdata[CF_FALL_THROUGH_MODE] = s.fall_through_mode;
                        n.rdata[CF_SERIAL] = s.serialMethod;
                        n.rdata[CF_ASYR] = s.asyncRead;
                        n.rdata[CF_ASYW] = s.asyncWrite;
                    end
                    default:
                    begin
                        n.rresp = RESP_SLVERR;
                    end
                endcase
            end
            BUS_RESP:
            begin
                if (rready)
                begin
                    n.rvalid = 1'b0;
                    n.rdBus = BUS_IDLE;
                end
            end
            default:
            begin
                n.rdBus = BUS_IDLE;
            end
        endcase

        // offset programming from the pins; bus writes take priority
        if (!axiOfs)
        begin
            if (!offsetLoadSelect && wrEvent && !s.serialMethod)
            begin
                if (s.wrOfsSel)
                begin
                    n.fullOfs = CNT_W'(dataIn);
                end
                else
                begin
                    n.emptyOfs = CNT_W'(dataIn);
                end
                n.wrOfsSel = !s.wrOfsSel;
            end
            else if (serialLoadEnable && inputStrobeGate && s.serialMethod)
            begin
                // shared pin carries the serial bit after master reset
                {n.fullOfs, n.emptyOfs} = {s.fullOfs[CNT_W-2:0], s.emptyOfs, fallThroughMode};
            end
        end

        // fifo write with x9 pairing, first byte in the low half
        if (wrEvent && offsetLoadSelect && !serialLoadEnable && curCount != FULL_CNT)
        begin
            if (s.write9 && !s.packHave)
            begin
                n.packLow = dataIn[HALF_W-1:0];
                n.packHave = 1'b1;
            end
            else
            begin
                memWe = 1'b1;
                memData = s.write9 ? {dataIn[HALF_W-1:0], s.packLow} : dataIn;
                n.wrPtr = s.wrPtr + 1'b1;
                n.packHave = 1'b0;
            end
        end

        // offset readback instead of fifo data
        if (rdEvent && !offsetLoadSelect)
        begin
            n.dataOut = s.rdOfsSel ? WORD_W'(s.fullOfs) : WORD_W'(s.emptyOfs);
            n.rdOfsSel = !s.rdOfsSel;
        end

        // fifo read; x9 mode shows low half, then high half
        if (rdEvent && offsetLoadSelect && !s.readBlock && (s.outValid || !s.fall_through_mode))
        begin
            if (takeHigh)
            begin
                n.dataOut = WORD_W'(s.outWord[WORD_W-1:HALF_W]);
                n.halfSel = 1'b0;
            end
            else if (s.fall_through_mode)
            begin
                n.outValid = 1'b0;
            end
            else
            begin
                doLoad = notEmpty;
            end
        end
        if (s.fall_through_mode && !n.outValid && notEmpty && !s.readBlock)
        begin
            doLoad = 1'b1;
        end
        if (doLoad)
        begin
            n.rdPtr = s.rdPtr + 1'b1;
            n.outValid = 1'b1;
            n.outWord = memQ;
            n.halfSel = s.read9;
            n.dataOut = s.read9 ? WORD_W'(memQ[HALF_W-1:0]) : memQ;
        end

        // replay from location zero; normal latency blocks one read cycle
        if (replayRequest && masterResetN && partialResetN)
        begin
            // address zero; wrap bit follows the writer so the count stays in range
            n.rdPtr = {s.wrPtr[ADDR_W], ADDR_W'(0)};
            n.outValid = 1'b0;
            n.halfSel = 1'b0;
            n.readBlock = s.retransNormal;
            forceEmpty = 1'b1;
        end

        if (!partialResetN || !masterResetN)
        begin
            n.wrPtr = '0;
            n.rdPtr = '0;
            n.dataOut = '0;
            n.outWord = '0;
            n.outValid = 1'b0;
            n.halfSel = 1'b0;
            n.packHave = 1'b0;
            n.wrOfsSel = 1'b0;
            n.rdOfsSel = 1'b0;
            memWe = 1'b0;
            forceEmpty = 1'b1;
        end
        if (!masterResetN)
        begin
            n.read9 = readWidthSelect;
            n.write9 = writeWidthSelect;
            n.flagSync = flagTimingSelect;
            n.retransNormal = retransmitLatencySelect;
            n.fall_through_mode = fallThroughMode && asyncReadSelect;
            n.serialMethod = offsetLoadSelect;
            n.asyncRead = !asyncReadSelect;
            n.asyncWrite = !asyncWriteSelect;
            n.emptyOfs = CNT_W'(DEF_EMPTY_OFS);
            n.fullOfs = CNT_W'(DEF_FULL_OFS);
        end

        if (n.read9)
        begin
            n.dataOut[WORD_W-1:HALF_W] = '0;
        end

        // flags: almost flags follow the new count in async timing, lag a cycle in sync; full follows the new count, empty too outside fall-through mode
        nextCount = countOf(n.wrPtr, n.rdPtr);
        cntSel = s.flagSync ? curCount : nextCount;
        n.almostEmptyFlag = cntSel >= (s.flagSync ? s.emptyOfs : n.emptyOfs);
        n.almostFullFlag = (FULL_CNT - cntSel) > (s.flagSync ? s.fullOfs : n.fullOfs);
        n.fullFlag = nextCount == FULL_CNT;
        n.emptyFlag = n.fall_through_mode ? n.outValid : (forceEmpty || (nextCount == '0 && !n.halfSel));
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.emptyOfs <= CNT_W'(DEF_EMPTY_OFS);
            s.fullOfs <= CNT_W'(DEF_FULL_OFS);
            s.emptyFlag <= 1'b1;
            s.almostFullFlag <= FULL_CNT > CNT_W'(DEF_FULL_OFS);
        end
        else
        begin
            s <= n;
        end
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bresp = s.bresp;
    assign bvalid = s.bvalid;
    assign arready = s.arready;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign rvalid = s.rvalid;
    assign dataOut = s.dataOut;
    assign emptyFlag = s.emptyFlag;
    assign fullFlag = s.fullFlag;
    assign almostEmptyFlag = s.almostEmptyFlag;
    assign almostFullFlag = s.almostFullFlag;

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_strap_release;
        !masterResetN ##1 masterResetN;
    endsequence
    sequence s_running;
        masterResetN && partialResetN;
    endsequence

    property p_rd_width;
        s_strap_release |-> s.read9 == $past(readWidthSelect);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read width not latched");
    property p_wr_width;
        s_strap_release |-> s.write9 == $past(writeWidthSelect);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write width not latched");
    property p_flag_mode;
        s_strap_release |-> s.flagSync == $past(flagTimingSelect);
    endproperty
    a_flag_mode: assert property (p_flag_mode) else $error("flag timing not latched");
    property p_rt_mode;
        s_strap_release |-> s.retransNormal == $past(retransmitLatencySelect);
    endproperty
    a_rt_mode: assert property (p_rt_mode) else $error("retransmit mode not latched");
    property p_master;
        !masterResetN |=> curCount == '0 && s.dataOut == '0 && s.emptyOfs == CNT_W'(DEF_EMPTY_OFS);
    endproperty
    a_master: assert property (p_master) else $error("master reset incomplete");
    property p_partial;
        (!partialResetN && masterResetN) |=> curCount == '0 && s.dataOut == '0
            && s.fall_through_mode == $past(s.fall_through_mode) && s.read9 == $past(s.read9);
    endproperty
    a_partial: assert property (p_partial) else $error("partial reset wrong");
    property p_ae_sync;
        s_running ##0 s.flagSync |=> almostEmptyFlag == ($past(curCount) >= $past(s.emptyOfs));
    endproperty
    a_ae_sync: assert property (p_ae_sync) else $error("almost-empty wrong");
    property p_af_async;
        ($past(masterResetN) && !s.flagSync) |-> almostFullFlag == ((FULL_CNT - curCount) > s.fullOfs);
    endproperty
    a_af_async: assert property (p_af_async) else $error("almost-full wrong");
    property p_replay;
        s_running ##0 replayRequest |=> s.rdPtr[ADDR_W-1:0] == '0 && emptyFlag == !s.fall_through_mode;
    endproperty
    a_replay: assert property (p_replay) else $error("replay did not restart");
    property p_full_hold;
        s_running ##0 (curCount == FULL_CNT && wrEvent) |=> s.wrPtr == $past(s.wrPtr);
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("write while full");
    property p_gate;
        s_running ##0 !inputStrobeGate |=> $stable(s.wrPtr);
    endproperty
    a_gate: assert property (p_gate) else $error("write without gate");
    property p_sync_write;
        (!s.asyncWrite && !s.write9 && wrEvent && offsetLoadSelect && !serialLoadEnable
            && curCount < FULL_CNT) ##0 s_running
            |=> s.wrPtr == CNT_W'($past(s.wrPtr) + 1'b1);
    endproperty
    a_sync_write: assert property (p_sync_write) else $error("sync write lost");
    property p_async_level;
        s_running ##0 (s.asyncWrite && inputStrobe && s.prevWrStrobe) |=> $stable(s.wrPtr);
    endproperty
    a_async_level: assert property (p_async_level) else $error("held strobe wrote");
    property p_rd_enable;
        (!s.asyncRead && !s.fall_through_mode && !readStrobeEnable && !replayRequest) ##0 s_running
            |=> $stable(s.rdPtr);
    endproperty
    a_rd_enable: assert property (p_rd_enable) else $error("read without enable");
    property p_ofs_read;
        (!offsetLoadSelect && rdEvent && !s.rdOfsSel && !s.read9) ##0 s_running
            |=> s.dataOut == WORD_W'($past(s.emptyOfs));
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("offset readback wrong");
    property p_x9_upper;
        s.read9 |-> s.dataOut[WORD_W-1:HALF_W] == '0;
    endproperty
    a_x9_upper: assert property (p_x9_upper) else $error("upper outputs driven in x9");
endmodule

// ==== tb/dcbmf_agents.sv ====
// writing and reading agents facing the fifo ports
module dcbmf_agents
    import dcbmf_pkg::*;
(
    input wire logic sys_clk,
    output logic inputStrobeGate,
    output logic [WORD_W-1:0] dataIn,
    output logic readStrobeEnable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        inputStrobeGate = 1'b0;
        dataIn = '0;
        readStrobeEnable = 1'b0;
    end
    // one gated edge per word, data scrambled while the gate is low
    task automatic push(input logic [WORD_W-1:0] d);
        @(posedge sys_clk);
        inputStrobeGate <= 1'b1;
        dataIn <= d;
        @(posedge sys_clk);
        inputStrobeGate <= 1'b0;
        dataIn <= ~d;
    endtask
    task automatic pop();
        @(posedge sys_clk);
        readStrobeEnable <= 1'b1;
        @(posedge sys_clk);
        readStrobeEnable <= 1'b0;
    endtask
endmodule

// ==== tb/test_dual_clock_bus_matching_fifo_ports.sv ====
// self-checking bench for the fifo port block
module test_dual_clock_bus_matching_fifo_ports
    import dcbmf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, masterResetN, partialResetN, readWidthSelect, writeWidthSelect;
    logic flagTimingSelect, retransmitLatencySelect, fallThroughMode, offsetLoadSelect;
    logic asyncReadSelect, asyncWriteSelect, serialLoadEnable, inputStrobeGate, inputStrobe;
    logic readStrobeEnable, readStrobe, replayRequest, emptyFlag, fullFlag;
    logic almostEmptyFlag, almostFullFlag;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [WORD_W-1:0] dataIn, dataOut;
    int fails = 0;
    int cmp_count = 0;
    dcbmf_ports #(.DEPTH(16)) dut (.sys_clk, .reset, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .masterResetN, .partialResetN, .readWidthSelect,
        .writeWidthSelect, .flagTimingSelect, .retransmitLatencySelect, .fallThroughMode,
        .offsetLoadSelect, .asyncReadSelect, .asyncWriteSelect, .serialLoadEnable,
        .inputStrobeGate, .inputStrobe, .dataIn, .readStrobeEnable, .readStrobe,
        .replayRequest, .dataOut, .emptyFlag, .fullFlag, .almostEmptyFlag, .almostFullFlag);
    dcbmf_agents agent (.sys_clk, .inputStrobeGate, .dataIn, .readStrobeEnable);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do @(posedge sys_clk); while ((awready & wready) !== 1'b1);
        {awvalid, wvalid} <= 2'h0;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // pins against a word count, offsets 2 and 3, depth 16
    task automatic flags(input int n);
        @(negedge sys_clk);
        chk(emptyFlag, n == 0);
        chk(fullFlag, n == 16);
        chk(almostEmptyFlag, n >= 2);
        chk(almostFullFlag, 16 - n > 3);
    endtask
    task automatic results();
        $display("fails %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        #200000;
        fails++;
        results();
    end
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        {readWidthSelect, writeWidthSelect, flagTimingSelect, retransmitLatencySelect} = 4'h0;
        {fallThroughMode, serialLoadEnable, inputStrobe, readStrobe, replayRequest} = 5'h00;
        {asyncReadSelect, asyncWriteSelect, offsetLoadSelect} = 3'h7;
        {masterResetN, partialResetN, wstrb, reset} = 7'h7F;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        masterResetN <= 1'b0;
        @(posedge sys_clk);
        masterResetN <= 1'b1;
        axr(REG_CONFIG, rd, rs);
        chk(rd[5:0], 6'h20);
        axr(8'h10, rd, rs);
        chk(rd, 32'h0);
        chk(rs, RESP_SLVERR);
        axw(8'h10, 32'h1, rs);
        chk(rs, RESP_SLVERR);
        axw(REG_EMPTY_OFS, 32'h2, rs);
        axw(REG_FULL_OFS, 32'h3, rs);
        axr(REG_STATUS, rd, rs);
        chk(rd[12:0], 13'h0009);
        $display("setup done");
        for (int i = 0; i < 17; i++)
        begin
            agent.push(18'h00100 + 18'(i));
            flags(i < 16 ? i + 1 : 16);
        end
        for (int i = 0; i < 17; i++)
        begin
            agent.pop();
            flags(i < 16 ? 15 - i : 0);
            chk(dataOut, 18'h00100 + 18'(i < 16 ? i : 15));
        end
        $display("fill and drain done");
        for (int i = 0; i < 3; i++)
            agent.push(18'h3FE00 + 18'(i));
        agent.pop();
        agent.pop();
        @(posedge sys_clk);
        replayRequest <= 1'b1;
        @(posedge sys_clk);
        replayRequest <= 1'b0;
        @(negedge sys_clk);
        chk(emptyFlag, 1'b1);
        axr(REG_STATUS, rd, rs);
        chk(rd[12:8], 5'h03);
        agent.pop();
        @(negedge sys_clk);
        chk(dataOut, 18'h3FE00);
        $display("replay done");
        @(posedge sys_clk);
        partialResetN <= 1'b0;
        @(posedge sys_clk);
        partialResetN <= 1'b1;
        @(negedge sys_clk);
        chk({dataOut, emptyFlag}, {18'h0, 1'b1});
        axr(REG_EMPTY_OFS, rd, rs);
        chk(rd, 32'h2);
        offsetLoadSelect <= 1'b0;
        agent.pop();
        @(negedge sys_clk);
        chk(dataOut, 18'h2);
        agent.pop();
        @(negedge sys_clk);
        chk(dataOut, 18'h3);
        $display("partial reset and offsets done");
        @(posedge sys_clk);
        {readWidthSelect, writeWidthSelect, flagTimingSelect, masterResetN} <= 4'hE;
        @(posedge sys_clk);
        {masterResetN, offsetLoadSelect} <= 2'h3;
        axr(REG_CONFIG, rd, rs);
        chk(rd[7:0], 8'h07);
        agent.push(18'h3FE55);
        agent.push(18'h000AA);
        agent.pop();
        @(negedge sys_clk);
        chk(dataOut, 18'h00055);
        agent.pop();
        @(negedge sys_clk);
        chk(dataOut, 18'h000AA);
        $display("x9 restart done");
        results();
    end
endmodule
